// [rtl/arf_pkg.sv]
// Package with constants and carrier types for the graphics port request logic.
`default_nettype none
package arf_pkg;

  // ---------------------------------------------------------------------
  // Widths, codes and encodings
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned SIDE_W    = 8;
  localparam int unsigned STAT_W    = 3;
  localparam int unsigned QCNT_W    = 5;

  // Status bus code that lets the master start a FRAME# transaction.
  localparam logic [2:0] ST_FRAME_GO = 3'h7;
  // Status bus value while nothing is granted (the bus idles high).
  localparam logic [2:0] ST_IDLE     = 3'h7;
  localparam logic [2:0] ST_RESET    = 3'h7;

  // Enqueue method codes.
  localparam logic [1:0] METH_NONE  = 2'h0;
  localparam logic [1:0] METH_PIPE  = 2'h1;
  localparam logic [1:0] METH_SIDE  = 2'h2;

  // Read-data return state machine, one-hot.
  typedef enum logic [1:0] {
    ARF_RD_IDLE = 2'h1,
    ARF_RD_BUSY = 2'h2
  } arf_rd_state_t;

  // One captured request from the pipe enqueue path.
  typedef struct packed {
    logic              valid;
    logic              from_side;
    logic [ADDR_W-1:0] addr;
  } arf_req_t;

  // Throttle inputs after synchronisation.
  typedef struct packed {
    logic rbf_n;
    logic wbf_n;
  } arf_thr_t;

endpackage : arf_pkg
`default_nettype wire

// [rtl/arf_sync.sv]
// Two-flop synchroniser for a bundle of asynchronous pin inputs.
`timescale 1ns/100ps
`default_nettype none
module arf_sync #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } arf_sync_st_t;

  arf_sync_st_t st_reg;
  arf_sync_st_t st_next;

  // First stage feeds only the second stage.
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  // Register the state, constants only under reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= {INIT, INIT};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule : arf_sync
`default_nettype wire

// [rtl/arf_core.sv]
// Target-side request enqueue, flow control and status bus of the port.
`timescale 1ns/100ps
`default_nettype none
module arf_core (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Configuration: method choice and its one-shot load strobe.
  input  wire logic [1:0]                 cfg_method,
  input  wire logic                       cfg_load,
  input  wire logic                       frame_mode,
  // Pins from the graphics master.
  input  wire logic                       pipe_n,
  input  wire logic [arf_pkg::ADDR_W-1:0] ad_in,
  input  wire logic [arf_pkg::SIDE_W-1:0] sba_in,
  input  wire logic                       rbf_n,
  input  wire logic                       wbf_n,
  input  wire logic                       rbf_present,
  input  wire logic                       wbf_present,
  // Arbiter side.
  input  wire logic                       gnt_n,
  input  wire logic [arf_pkg::STAT_W-1:0] arb_status,
  input  wire logic                       frame_grant,
  // Read-data return engine.
  input  wire logic                       rd_lp_pending,
  input  wire logic                       rd_last,
  output logic                            rd_start,
  output logic                            rd_active,
  // Fast write data engine.
  input  wire logic                       fw_pending,
  output logic                            fw_go,
  // Request queue write port.
  output arf_pkg::arf_req_t               req_out,
  output logic [arf_pkg::SIDE_W-1:0]      side_byte,
  output logic                            side_valid,
  output logic [1:0]                      method,
  // Status pins to the master.
  output logic [arf_pkg::STAT_W-1:0]      st_out,
  output logic                            st_oe
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  localparam int unsigned SW = 3 + arf_pkg::ADDR_W + arf_pkg::SIDE_W;

  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_syn;

  // Pins cross into the clock domain through two flops each.
  assign pin_raw = {pipe_n, rbf_n, wbf_n, ad_in, sba_in};

  arf_sync #(
    .W    (SW),
    .INIT ({3'h7, {(arf_pkg::ADDR_W + arf_pkg::SIDE_W){1'b0}}})
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pin_raw),
    .q     (pin_syn)
  );

  logic                       pipe_s_n;
  arf_pkg::arf_thr_t          thr_s;
  logic [arf_pkg::ADDR_W-1:0] ad_s;
  logic [arf_pkg::SIDE_W-1:0] sba_s;

  // Unpack the synchronised pins.
  assign pipe_s_n    = pin_syn[SW-1];
  assign thr_s.rbf_n = pin_syn[SW-2];
  assign thr_s.wbf_n = pin_syn[SW-3];
  assign ad_s        = pin_syn[arf_pkg::ADDR_W+arf_pkg::SIDE_W-1 -:
                               arf_pkg::ADDR_W];
  assign sba_s       = pin_syn[arf_pkg::SIDE_W-1:0];

  // ---------------------------------------------------------------------
  // Helper function
  // ---------------------------------------------------------------------
  // A throttle counts only when the master implements it.
  function automatic logic thr_full(input logic pin_n, input logic present);
    thr_full = present & ~pin_n;
  endfunction : thr_full

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                 method;
    logic                       locked;
    arf_pkg::arf_rd_state_t     rd_state;
    logic                       rd_start;
    arf_pkg::arf_req_t          req;
    logic [arf_pkg::SIDE_W-1:0] side_byte;
    logic                       side_valid;
    logic                       fw_go;
    logic [arf_pkg::STAT_W-1:0] st;
    logic                       st_oe;
  } arf_core_st_t;

  arf_core_st_t st_reg;
  arf_core_st_t st_next;

  logic pipe_use;
  logic side_use;
  logic rbf_full;
  logic wbf_full;

  // Path enables follow the locked method and the FRAME mode.
  assign pipe_use = st_reg.locked && (st_reg.method == arf_pkg::METH_PIPE)
                    && !frame_mode;
  assign side_use = st_reg.locked && (st_reg.method == arf_pkg::METH_SIDE)
                    && !frame_mode;
  assign rbf_full = thr_full(thr_s.rbf_n, rbf_present);
  assign wbf_full = thr_full(thr_s.wbf_n, wbf_present);

  // Next-state logic for every register of the block.
  always_comb begin
    st_next            = st_reg;
    st_next.rd_start   = 1'b0;
    st_next.req.valid  = 1'b0;
    st_next.side_valid = 1'b0;

    // The method is loaded once and then held until reset.
    if (cfg_load && !st_reg.locked) begin
      st_next.method = cfg_method;
      st_next.locked = 1'b1;
    end

    // One full-width address per edge while pipe is asserted.
    if (pipe_use && !pipe_s_n) begin
      st_next.req.valid     = 1'b1;
      st_next.req.from_side = 1'b0;
      st_next.req.addr      = ad_s;
    end

    // Sideband bytes flow on their own path, one per edge while selected.
    if (side_use) begin
      st_next.side_valid = 1'b1;
      st_next.side_byte  = sba_s;
    end

    // Read-full is looked at only when a new return would start.
    case (st_reg.rd_state)
      arf_pkg::ARF_RD_IDLE: begin
        if (!frame_mode && rd_lp_pending && !rbf_full) begin
          st_next.rd_start = 1'b1;
          st_next.rd_state = arf_pkg::ARF_RD_BUSY;
        end
      end
      arf_pkg::ARF_RD_BUSY: begin
        // An ongoing return finishes regardless of read-full.
        if (rd_last) begin
          st_next.rd_state = arf_pkg::ARF_RD_IDLE;
        end
      end
      default: begin
        st_next.rd_state = arf_pkg::ARF_RD_IDLE;
      end
    endcase

    // Fast write data only while write-full is clear.
    st_next.fw_go = fw_pending && !wbf_full && !frame_mode;

    // Status bus: arbiter code under grant, FRAME code in FRAME mode.
    st_next.st_oe = 1'b1;
    if (frame_mode) begin
      st_next.st = frame_grant ? arf_pkg::ST_FRAME_GO
                               : arf_pkg::ST_IDLE;
    end else if (!gnt_n) begin
      st_next.st = arb_status;
    end else begin
      st_next.st = arf_pkg::ST_IDLE;
    end
  end

  // Register the whole state; reset loads constants only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg            <= '0;
      st_reg.method     <= arf_pkg::METH_NONE;
      st_reg.rd_state   <= arf_pkg::ARF_RD_IDLE;
      st_reg.st         <= arf_pkg::ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs all come from the state register.
  assign req_out    = st_reg.req;
  assign side_byte  = st_reg.side_byte;
  assign side_valid = st_reg.side_valid;
  assign method     = st_reg.method;
  assign rd_start   = st_reg.rd_start;
  assign rd_active  = (st_reg.rd_state == arf_pkg::ARF_RD_BUSY);
  assign fw_go      = st_reg.fw_go;
  assign st_out     = st_reg.st;
  assign st_oe      = st_reg.st_oe;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  chk_pipe_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (pipe_use && !pipe_s_n) |=> (req_out.valid && req_out.addr == $past(ad_s)))
    else $error("Pipe address not captured.");

  chk_pipe_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    !pipe_use |=> !req_out.valid)
    else $error("Pipe address taken while path disabled.");

  chk_side_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    !side_use |=> !side_valid)
    else $error("Sideband byte taken while path disabled.");

  chk_side_capture: assert property (@(posedge clk) disable iff (!rst_n)
    side_use |=> (side_valid && side_byte == $past(sba_s)))
    else $error("Sideband byte not captured.");

  chk_rbf_start: assert property (@(posedge clk) disable iff (!rst_n)
    rd_start |-> ($past(!rbf_full) && $past(!rd_active)))
    else $error("Read return started under read-full.");

  chk_rbf_finish: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_active && !rd_last) |=> rd_active)
    else $error("Read return cut short.");

  chk_wbf_block: assert property (@(posedge clk) disable iff (!rst_n)
    wbf_full |=> !fw_go)
    else $error("Fast write driven under write-full.");

  chk_method_held: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.locked |=> (method == $past(method)))
    else $error("Enqueue method changed after lock.");

  chk_frame_code: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_mode && frame_grant) |=> (st_out == arf_pkg::ST_FRAME_GO))
    else $error("FRAME start code not driven.");

  chk_status_gnt: assert property (@(posedge clk) disable iff (!rst_n)
    (!frame_mode && !gnt_n) |=> (st_out == $past(arb_status)))
    else $error("Arbiter status not forwarded.");

  // Path enables also follow the locked method and the FRAME mode level.
  chk_pipe_frame: assert property (@(posedge clk) disable iff (!rst_n)
    frame_mode |=> !req_out.valid)
    else $error("Pipe address taken in FRAME mode.");

  chk_pipe_method: assert property (@(posedge clk) disable iff (!rst_n)
    (method != arf_pkg::METH_PIPE) |=> !req_out.valid)
    else $error("Pipe address taken under another method.");

  chk_side_frame: assert property (@(posedge clk) disable iff (!rst_n)
    frame_mode |=> !side_valid)
    else $error("Sideband byte taken in FRAME mode.");

  chk_side_method: assert property (@(posedge clk) disable iff (!rst_n)
    (method != arf_pkg::METH_SIDE) |=> !side_valid)
    else $error("Sideband byte taken under another method.");

  // A return pulse opens a busy span that only the last beat closes.
  chk_rd_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    rd_start |-> rd_active)
    else $error("Read start without an active return.");

  chk_rd_no_restart: assert property (@(posedge clk) disable iff (!rst_n)
    rd_active |=> !rd_start)
    else $error("Second read return started while busy.");

  chk_rd_end: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_active && rd_last) |=> !rd_active)
    else $error("Read return did not end after last beat.");

  chk_rd_absent: assert property (@(posedge clk) disable iff (!rst_n)
    (!rbf_present && rd_lp_pending && !rd_active && !frame_mode) |=> rd_start)
    else $error("Read return stalled by an absent throttle.");

  // Fast write data follows the throttle and the FRAME mode level.
  chk_fw_frame: assert property (@(posedge clk) disable iff (!rst_n)
    frame_mode |=> !fw_go)
    else $error("Fast write driven in FRAME mode.");

  chk_fw_free: assert property (@(posedge clk) disable iff (!rst_n)
    (fw_pending && !wbf_present && !frame_mode) |=> fw_go)
    else $error("Fast write stalled by an absent throttle.");

  // The status bus idles high and is driven from the first edge on.
  chk_status_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (!frame_mode && gnt_n) |=> (st_out == arf_pkg::ST_IDLE))
    else $error("Status bus not idle without grant.");

  chk_status_drive: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> st_oe)
    else $error("Status bus not driven.");

  chk_method_load: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_load && !st_reg.locked) |=> (method == $past(cfg_method)))
    else $error("Enqueue method not loaded.");

endmodule : arf_core
`default_nettype wire

// [dv/arf_master_model.sv]
// Graphics master model that drives the request and throttle pins.
`timescale 1ns/100ps
`default_nettype none
module arf_master_model (
  input  wire logic                   clk,
  output logic                        pipe_n,
  output logic [arf_pkg::ADDR_W-1:0]  ad_in,
  output logic [arf_pkg::SIDE_W-1:0]  sba_in,
  output logic                        rbf_n,
  output logic                        wbf_n
);
  // Pins start idle: pipe and both throttles deasserted.
  initial begin
    pipe_n = 1'b1;
    ad_in  = 32'h0;
    sba_in = 8'hFF;
    rbf_n  = 1'b1;
    wbf_n  = 1'b1;
  end
  // Presents one full-width address with pipe low; pipe stays low until pipe_end.
  task automatic pipe_word(input logic [31:0] a);
    @(posedge clk);
    pipe_n <= 1'b0;
    ad_in  <= a;
  endtask : pipe_word
  // Ends a burst; released AD shows the inverse of its last value.
  task automatic pipe_end();
    @(posedge clk);
    pipe_n <= 1'b1;
    ad_in  <= ~ad_in;
  endtask : pipe_end
  // Places one sideband byte; it stays on the pins until the next one is placed.
  task automatic side_word(input logic [7:0] b);
    @(posedge clk);
    sba_in <= b;
  endtask : side_word
  // Sets the buffer-full pins; an absent throttle is marked by the bench.
  task automatic throttle(input logic r, input logic w);
    @(posedge clk);
    rbf_n <= r;
    wbf_n <= w;
  endtask : throttle
endmodule : arf_master_model
`default_nettype wire

// [dv/arf_core_tb.sv]
// Self-checking bench for the port request, throttle and status logic.
`timescale 1ns/100ps
`default_nettype none
module arf_core_tb;
  logic                 clk, rst_n, cfg_load, frame_mode, frame_grant;
  logic                 rbf_present, wbf_present, gnt_n, fw_pending;
  logic                 rd_lp_pending, rd_last, pipe_n, rbf_n, wbf_n;
  logic                 rd_start, rd_active, fw_go, side_valid, st_oe;
  logic [1:0]           cfg_method, method;
  logic [2:0]           arb_status, st_out;
  logic [31:0]          ad_in;
  logic [7:0]           sba_in, side_byte;
  arf_pkg::arf_req_t    req_out;
  int                   fails, n_tests, i;

  // ----
  // Clock, partner and design
  // ----
  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  arf_master_model arf_master_model_i (.clk(clk), .pipe_n(pipe_n),
    .ad_in(ad_in), .sba_in(sba_in), .rbf_n(rbf_n), .wbf_n(wbf_n));
  arf_core arf_core_i (.clk(clk), .rst_n(rst_n), .cfg_method(cfg_method),
    .cfg_load(cfg_load), .frame_mode(frame_mode), .pipe_n(pipe_n),
    .ad_in(ad_in), .sba_in(sba_in), .rbf_n(rbf_n), .wbf_n(wbf_n),
    .rbf_present(rbf_present), .wbf_present(wbf_present), .gnt_n(gnt_n),
    .arb_status(arb_status), .frame_grant(frame_grant),
    .rd_lp_pending(rd_lp_pending), .rd_last(rd_last),
    .rd_start(rd_start), .rd_active(rd_active), .fw_pending(fw_pending),
    .fw_go(fw_go), .req_out(req_out), .side_byte(side_byte),
    .side_valid(side_valid), .method(method), .st_out(st_out),
    .st_oe(st_oe));

  // ----
  // Helpers
  // ----
  // Moves just past the next rising edge, where outputs are settled.
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  // Compares a value and counts the comparison.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // Resets the block and loads one enqueue method, then tries another.
  task automatic do_reset(input logic [1:0] m);
    @(posedge clk) rst_n <= 1'b0;
    step();
    chk("st_out_rst", 32'h7, st_out);
    chk("method_rst", 32'h0, method);
    @(posedge clk) rst_n <= 1'b1;
    @(posedge clk) begin
      cfg_load   <= 1'b1;
      cfg_method <= m;
    end
    @(posedge clk) cfg_method <= ~m;
    @(posedge clk) cfg_load <= 1'b0;
    step();
    chk("method", m, method);
  endtask : do_reset
  // Ends the run with the verdict.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // ----
  // Scenarios
  // ----
  // Back-to-back pipe addresses, one per edge; sideband stays unused.
  task automatic t_pipe();
    do_reset(arf_pkg::METH_PIPE);
    arf_master_model_i.pipe_word(32'hA5A50001);
    arf_master_model_i.pipe_word(32'h5A5A0002);
    arf_master_model_i.pipe_end();
    for (i = 0; i < 6 && req_out.valid !== 1'b1; i++) step();
    chk("addr0", 32'hA5A50001, req_out.addr);
    chk("from_side", 32'h0, req_out.from_side);
    chk("side_valid", 32'h0, side_valid);
    step();
    chk("valid1", 32'h1, req_out.valid);
    chk("addr1", 32'h5A5A0002, req_out.addr);
    step();
    chk("valid2", 32'h0, req_out.valid);
  endtask : t_pipe
  // Pipe is ignored here; sideband is taken only when selected, not FRAME.
  task automatic t_ignore(input logic [1:0] m, input logic f);
    logic seen;
    logic side_seen;
    logic hit;
    logic side_on;
    do_reset(m);
    seen      = 1'b0;
    side_seen = 1'b0;
    hit       = 1'b0;
    side_on   = (m == arf_pkg::METH_SIDE) && !f;
    @(posedge clk) frame_mode <= f;
    arf_master_model_i.pipe_word(32'h12345678);
    arf_master_model_i.side_word(8'h3C);
    arf_master_model_i.side_word(8'hC3);
    arf_master_model_i.pipe_end();
    for (i = 0; i < 6; i++) begin
      step();
      seen      = seen | req_out.valid;
      side_seen = side_seen | side_valid;
      if (side_byte === 8'h3C) begin
        hit = 1'b1;
        step();
        chk("side_byte", 32'hC3, side_byte);
        chk("side_valid", 32'h1, side_valid);
      end
    end
    chk("req_ignored", 32'h0, seen);
    chk("side_used", {31'h0, side_on}, side_seen);
    chk("side_hit", {31'h0, side_on}, hit);
    @(posedge clk) frame_mode <= 1'b0;
  endtask : t_ignore
  // Read return held off by read-full, not stopped mid-transfer.
  task automatic t_read();
    do_reset(arf_pkg::METH_PIPE);
    @(posedge clk) rbf_present <= 1'b1;
    arf_master_model_i.throttle(1'b0, 1'b1);
    repeat (3) step();
    @(posedge clk) rd_lp_pending <= 1'b1;
    repeat (4) step();
    chk("rd_held", 32'h0, {rd_start, rd_active});
    arf_master_model_i.throttle(1'b1, 1'b1);
    for (i = 0; i < 6 && rd_active !== 1'b1; i++) step();
    chk("rd_start", 32'h1, rd_start);
    arf_master_model_i.throttle(1'b0, 1'b1);
    repeat (4) step();
    chk("rd_mid", 32'h1, rd_active);
    @(posedge clk) rd_last <= 1'b1;
    @(posedge clk) rd_last <= 1'b0;
    #1;
    chk("rd_done", 32'h0, rd_active);
    repeat (3) step();
    chk("rd_next_held", 32'h0, rd_active);
    @(posedge clk) rbf_present <= 1'b0;
    for (i = 0; i < 6 && rd_active !== 1'b1; i++) step();
    chk("rd_absent", 32'h1, rd_active);
    @(posedge clk) rd_lp_pending <= 1'b0;
  endtask : t_read
  // Fast write blocked by write-full unless the throttle is absent.
  task automatic t_fw();
    @(posedge clk) begin
      fw_pending  <= 1'b1;
      wbf_present <= 1'b1;
    end
    arf_master_model_i.throttle(1'b1, 1'b0);
    repeat (4) step();
    chk("fw_full", 32'h0, fw_go);
    arf_master_model_i.throttle(1'b1, 1'b1);
    repeat (4) step();
    chk("fw_free", 32'h1, fw_go);
    arf_master_model_i.throttle(1'b1, 1'b0);
    @(posedge clk) wbf_present <= 1'b0;
    repeat (4) step();
    chk("fw_absent", 32'h1, fw_go);
  endtask : t_fw
  // Status follows the arbiter under grant, idles 7, FRAME go is 7.
  task automatic t_status();
    @(posedge clk) begin
      gnt_n      <= 1'b0;
      arb_status <= 3'h5;
    end
    repeat (2) step();
    chk("st_grant", 32'h5, st_out);
    chk("st_oe", 32'h1, st_oe);
    @(posedge clk) gnt_n <= 1'b1;
    repeat (2) step();
    chk("st_idle", 32'h7, st_out);
    @(posedge clk) begin
      gnt_n       <= 1'b0;
      frame_mode  <= 1'b1;
      frame_grant <= 1'b1;
    end
    repeat (2) step();
    chk("st_frame", 32'h7, st_out);
    @(posedge clk) frame_mode <= 1'b0;
  endtask : t_status

  // ----
  // Main sequence and watchdog
  // ----
  // Drives inputs idle, holds reset two cycles and runs every scenario.
  initial begin
    {rst_n, cfg_load, frame_mode, frame_grant, rbf_present} = '0;
    {wbf_present, fw_pending, rd_lp_pending, rd_last} = '0;
    {cfg_method, arb_status, gnt_n} = {2'h0, 3'h0, 1'b1};
    t_pipe();
    t_ignore(arf_pkg::METH_SIDE, 1'b0);
    t_ignore(arf_pkg::METH_SIDE, 1'b1);
    t_ignore(arf_pkg::METH_PIPE, 1'b1);
    t_ignore(arf_pkg::METH_NONE, 1'b0);
    t_read();
    t_fw();
    t_status();
    summarize();
  end
  // Cuts a hang short well after the scenarios should have ended.
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule : arf_core_tb
`default_nettype wire
